// ==== pkg/ebw_pkg.sv ====
/*
 * Shared constants for the external bus wait-state and bank-switch block:
 * register offsets, reset values, writable masks, field positions and
 * access space codes.
 * Assumes a 16-bit memory-mapped register port and an 18-bit program address.
 */
package ebw_pkg;

    // ============================================================
    // Register map
    localparam logic [7:0] EBW_OFS_WAIT_RANGES = 8'h28;
    localparam logic [7:0] EBW_OFS_BANK_SWITCH = 8'h29;
    localparam logic [7:0] EBW_OFS_WAIT_MULT = 8'h2b;

    // ============================================================
    // Reset values and writable bits
    localparam logic [15:0] EBW_RST_WAIT_RANGES = 16'h7fff;
    localparam logic [15:0] EBW_RST_BANK_SWITCH = 16'hf800;
    localparam logic [15:0] EBW_RST_WAIT_MULT = 16'h0000;
    localparam logic [15:0] EBW_WMASK_BANK_SWITCH = 16'hf905;
    localparam logic [15:0] EBW_WMASK_WAIT_MULT = 16'h0001;

    // ============================================================
    // Field positions
    localparam int EBW_BIT_XPA = 15;
    localparam int EBW_LSB_IO = 12;
    localparam int EBW_LSB_DATA_HI = 9;
    localparam int EBW_LSB_DATA_LO = 6;
    localparam int EBW_LSB_PROG_HI = 3;
    localparam int EBW_LSB_PROG_LO = 0;
    localparam int EBW_BIT_DOUBLE = 0;
    localparam int EBW_LSB_BANK_MASK = 12;
    localparam int EBW_BIT_PROG_DATA_READ_GAP = 11;
    localparam int EBW_BIT_INTERPROCESSOR_IRQ_REQUEST = 8;
    localparam int EBW_BIT_KEEPER = 2;
    localparam int EBW_BIT_BUS_OFF = 0;
    localparam int EBW_BIT_HALF = 15;
    localparam int EBW_LSB_BANK_ADDR = 12;
    localparam int EBW_LSB_PAGE = 16;

    // ============================================================
    // Timing
    localparam logic [3:0] EBW_MIN_WAITS = 4'h1;

    typedef enum logic [1:0] {
        EBW_SP_PROG,
        EBW_SP_DATA,
        EBW_SP_IO
    } ebw_space_t;

endpackage

// ==== verilog/ebw_wait_sel.sv ====
/*
 * Wait-count selector: picks the 3-bit base count for one access from the
 * wait-range register, applies the doubling option and the floor of one.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module ebw_wait_sel
    import ebw_pkg::*;
(
    // Configuration
    input wire logic [15:0] ranges,
    input wire logic dbl,
    // Access
    input wire ebw_space_t space,
    input wire logic [17:0] addr,
    // Result
    output logic [3:0] waits
);

    logic [2:0] base;
    logic [3:0] scaled;

    always_comb begin
        base = ranges[EBW_LSB_PROG_LO +: 3];
        unique case (space)
            EBW_SP_IO: base = ranges[EBW_LSB_IO +: 3];
            EBW_SP_DATA: base = addr[EBW_BIT_HALF] ?
                ranges[EBW_LSB_DATA_HI +: 3] : ranges[EBW_LSB_DATA_LO +: 3];
            EBW_SP_PROG: begin
                if (!ranges[EBW_BIT_XPA] && addr[EBW_BIT_HALF]) begin
                    base = ranges[EBW_LSB_PROG_HI +: 3];
                end
            end
        endcase
        scaled = dbl ? {base, 1'b0} : {1'b0, base};
        waits = (scaled < EBW_MIN_WAITS) ? EBW_MIN_WAITS : scaled;
    end

endmodule

// ==== verilog/ebw_bank_gap.sv ====
/*
 * Bank-switch gap detector: decides whether one idle cycle must precede an
 * access, from the previous external access and the bank-switch settings.
 * Purely combinational.
 */
`timescale 1ns/1ps
module ebw_bank_gap
    import ebw_pkg::*;
(
    // Settings
    input wire logic [3:0] bank_mask,
    input wire logic prog_data_read_gap,
    // Previous access
    input wire logic prev_valid,
    input wire ebw_space_t prev_space,
    input wire logic prev_rd,
    input wire logic [17:0] prev_addr,
    // Current access
    input wire ebw_space_t cur_space,
    input wire logic cur_rd,
    input wire logic [17:0] cur_addr,
    // Result
    output logic gap
);

    logic same_ps;
    logic bank_chg;
    logic page_chg;
    logic p2d;
    logic rd_swap;

    always_comb begin
        same_ps = (prev_space == cur_space) && (cur_space != EBW_SP_IO);
        bank_chg = ((prev_addr[EBW_LSB_BANK_ADDR +: 4] ^
            cur_addr[EBW_LSB_BANK_ADDR +: 4]) & bank_mask) != 4'h0;
        page_chg = (prev_space == EBW_SP_PROG) && (cur_space == EBW_SP_PROG)
            && (prev_addr[EBW_LSB_PAGE +: 2] != cur_addr[EBW_LSB_PAGE +: 2]);
        p2d = (prev_space == EBW_SP_PROG) && (cur_space == EBW_SP_DATA);
        // program read and data read swap
        rd_swap = prog_data_read_gap && prev_rd && cur_rd &&
            (((prev_space == EBW_SP_PROG) && (cur_space == EBW_SP_DATA)) ||
             ((prev_space == EBW_SP_DATA) && (cur_space == EBW_SP_PROG)));
        gap = prev_valid && ((same_ps && bank_chg) || page_chg || p2d ||
            rd_swap);
    end

endmodule

// ==== verilog/ebw_ctrl.sv ====
/*
 * External bus timing controller for one subsystem: wait-state generator,
 * bank-switch idle cycles, bus-off, bus keeper and interprocessor request.
 * Assumes the CPU holds a request stable until its acknowledge, that memory
 * data is valid on the last strobe cycle, and one instance per subsystem.
 */
//
// Overview of operation
// - Bit 15 of wait ranges selects which ranges program fields cover.
// - I/O accesses use wait field bits 14 to 12.
// - Upper data half uses wait field bits 11 to 9.
// - Lower data half uses wait field bits 8 to 6.
// - Selector clear: upper program half uses bits 5 to 3.
// - Bits 2 to 0 cover lower program half, or all when selector set.
// - Multiplier bit 0 doubles the base count, up to fourteen.
// - Reserved bits ignore writes and read as zero.
// - One idle cycle on bank crossing within program or data space.
// - One idle cycle on program to data or program page change.
// - Bank-switch settings of the bus-owning subsystem apply.
// - Bank mask picks compared high address bits; resets to all ones.
// - Bit 11 set inserts a cycle between program and data reads.
// - Writing one to bit 8 interrupts the other subsystem once.
// - Bit 2 is the bus keeper control, cleared by reset.
// - Bit 0 finishes current cycle, then drives the bus inactive.
// - Bus off locks the mode and hold bits.
// - Reset gives seven waits on every external access.
// - Every external access has at least one wait.
// - The owning subsystem's wait register times external accesses.
`timescale 1ns/1ps
module ebw_ctrl
    import ebw_pkg::*;
#(
    parameter logic SUBSYS_ID = 1'b0
)(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Memory-mapped register port
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    input wire logic [7:0] mmr_addr,
    input wire logic [15:0] mmr_wdata,
    output logic [15:0] mmr_rdata,
    // CPU access request
    input wire logic req_valid,
    input wire ebw_space_t req_space,
    input wire logic req_rd,
    input wire logic [17:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic req_ack,
    output logic [15:0] req_rdata,
    // External bus pins
    input wire logic subsystem_select_pin,
    output logic [17:0] ext_addr,
    output logic ext_prog_n,
    output logic ext_data_n,
    output logic ext_io_n,
    output logic ext_strobe_n,
    output logic ext_rw,
    input wire logic [15:0] ext_data_i,
    output logic [15:0] ext_data_o,
    output logic ext_data_oe,
    // Keeper and system controls
    output logic bus_keeper_enable,
    output logic [15:0] keeper_data,
    output logic mode_bits_locked,
    output logic interprocessor_irq_request
);

    typedef enum logic [1:0] {
        EBW_ST_IDLE,
        EBW_ST_GAP,
        EBW_ST_ACC
    } ebw_state_t;

    ebw_state_t state_q;
    logic [15:0] ranges_q;
    logic double_q;
    logic [15:0] bank_q;
    logic [2:0] sel_sync_q;
    logic owner_sel_q;
    logic owns;
    logic take;
    logic gap;
    logic [3:0] waits;
    logic [3:0] cnt_q;
    logic [3:0] waits_q;
    logic [17:0] addr_q;
    ebw_space_t space_q;
    logic rd_q;
    logic [15:0] wdata_q;
    logic prev_valid_q;
    ebw_space_t prev_space_q;
    logic prev_rd_q;
    logic [17:0] prev_addr_q;
    logic interprocessor_irq_request_old_q;
    logic ack_q;
    logic acc_end;

    // ============================================================
    // Subsystem select synchroniser
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sel_sync_q <= 3'h0;
            owner_sel_q <= 1'b0;
        end else begin
            sel_sync_q <= {sel_sync_q[1:0], subsystem_select_pin};
            if (sel_sync_q[1] == sel_sync_q[2]) begin
                owner_sel_q <= sel_sync_q[2];
            end
        end
    end

    // only the selected subsystem drives the bus
    assign owns = (owner_sel_q == SUBSYS_ID);

    // ============================================================
    // Register writes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ranges_q <= EBW_RST_WAIT_RANGES;
            double_q <= EBW_RST_WAIT_MULT[EBW_BIT_DOUBLE];
            bank_q <= EBW_RST_BANK_SWITCH;
        end else if (mmr_wr) begin
            if (mmr_addr == EBW_OFS_WAIT_RANGES) begin
                ranges_q <= mmr_wdata;
            end
            if (mmr_addr == EBW_OFS_WAIT_MULT) begin
                double_q <= mmr_wdata[EBW_BIT_DOUBLE];
            end
            if (mmr_addr == EBW_OFS_BANK_SWITCH) begin
                bank_q <= mmr_wdata & EBW_WMASK_BANK_SWITCH;
            end
        end
    end

    // ============================================================
    // Register reads
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mmr_rdata <= 16'h0000;
        end else if (mmr_rd) begin
            unique case (mmr_addr)
                EBW_OFS_WAIT_RANGES: mmr_rdata <= ranges_q;
                EBW_OFS_BANK_SWITCH: mmr_rdata <= bank_q;
                EBW_OFS_WAIT_MULT: mmr_rdata <=
                    {15'h0000, double_q} & EBW_WMASK_WAIT_MULT;
                default: mmr_rdata <= 16'h0000;
            endcase
        end
    end

    // ============================================================
    // Access timing
    ebw_wait_sel u_wait_sel (
        .ranges(ranges_q),
        .dbl(double_q),
        .space(req_space),
        .addr(req_addr),
        .waits(waits)
    );

    ebw_bank_gap u_bank_gap (
        .bank_mask(bank_q[EBW_LSB_BANK_MASK +: 4]),
        .prog_data_read_gap(bank_q[EBW_BIT_PROG_DATA_READ_GAP]),
        .prev_valid(prev_valid_q),
        .prev_space(prev_space_q),
        .prev_rd(prev_rd_q),
        .prev_addr(prev_addr_q),
        .cur_space(req_space),
        .cur_rd(req_rd),
        .cur_addr(req_addr),
        .gap(gap)
    );

    // no new cycle starts once the bus is switched off
    assign take = (state_q == EBW_ST_IDLE) && req_valid && !ack_q && owns &&
        !bank_q[EBW_BIT_BUS_OFF];
    assign acc_end = (state_q == EBW_ST_ACC) && (cnt_q == 4'h0);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= EBW_ST_IDLE;
            cnt_q <= 4'h0;
            waits_q <= 4'h0;
            addr_q <= 18'h00000;
            space_q <= EBW_SP_PROG;
            rd_q <= 1'b1;
            wdata_q <= 16'h0000;
        end else begin
            unique case (state_q)
                EBW_ST_IDLE: begin
                    if (take) begin
                        state_q <= gap ? EBW_ST_GAP : EBW_ST_ACC;
                        cnt_q <= waits;
                        waits_q <= waits;
                        addr_q <= req_addr;
                        space_q <= req_space;
                        rd_q <= req_rd;
                        wdata_q <= req_wdata;
                    end else begin
                        addr_q <= 18'h00000;
                        rd_q <= 1'b1;
                    end
                end
                EBW_ST_GAP: state_q <= EBW_ST_ACC;
                EBW_ST_ACC: begin
                    // one clock per wait, address held
                    if (cnt_q == 4'h0) begin
                        state_q <= EBW_ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Previous access history and CPU answer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_valid_q <= 1'b0;
            prev_space_q <= EBW_SP_PROG;
            prev_rd_q <= 1'b0;
            prev_addr_q <= 18'h00000;
            ack_q <= 1'b0;
            req_rdata <= 16'h0000;
        end else begin
            ack_q <= acc_end;
            if (acc_end) begin
                prev_valid_q <= 1'b1;
                prev_space_q <= space_q;
                prev_rd_q <= rd_q;
                prev_addr_q <= addr_q;
                if (rd_q) begin
                    req_rdata <= ext_data_i;
                end
            end
        end
    end

    assign req_ack = ack_q;

    // ============================================================
    // Pin drive
    always_comb begin
        ext_addr = addr_q;
        ext_rw = rd_q;
        ext_strobe_n = (state_q != EBW_ST_ACC);
        ext_prog_n = !((state_q == EBW_ST_ACC) && (space_q == EBW_SP_PROG));
        ext_data_n = !((state_q == EBW_ST_ACC) && (space_q == EBW_SP_DATA));
        ext_io_n = !((state_q == EBW_ST_ACC) && (space_q == EBW_SP_IO));
        ext_data_o = wdata_q;
        ext_data_oe = (state_q == EBW_ST_ACC) && !rd_q;
    end

    // ============================================================
    // Bus keeper
    // remember the last level seen on the data bus
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            keeper_data <= 16'h0000;
        end else if (ext_data_oe) begin
            keeper_data <= wdata_q;
        end else if (acc_end && rd_q) begin
            keeper_data <= ext_data_i;
        end
    end

    assign bus_keeper_enable = bank_q[EBW_BIT_KEEPER];

    // mode and hold bits frozen while bus is off
    assign mode_bits_locked = bank_q[EBW_BIT_BUS_OFF];

    // ============================================================
    // Interprocessor request
    // one pulse per zero-to-one change of the request bit
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            interprocessor_irq_request_old_q <= 1'b0;
            interprocessor_irq_request <= 1'b0;
        end else begin
            interprocessor_irq_request_old_q <= bank_q[EBW_BIT_INTERPROCESSOR_IRQ_REQUEST];
            interprocessor_irq_request <= bank_q[EBW_BIT_INTERPROCESSOR_IRQ_REQUEST] &&
                !interprocessor_irq_request_old_q;
        end
    end

    // ============================================================
    // Assertions
    logic [4:0] strobe_len_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strobe_len_q <= 5'h00;
        end else if (!ext_strobe_n) begin
            strobe_len_q <= strobe_len_q + 5'h01;
        end else begin
            strobe_len_q <= 5'h00;
        end
    end

    property p_min_wait;
        @(posedge clock) disable iff (!arst_n)
        $fell(ext_strobe_n) |-> !ext_strobe_n [*2];
    endproperty
    a_min_wait: assert property (p_min_wait)
        else $error("access shorter than one wait");

    property p_len;
        @(posedge clock) disable iff (!arst_n)
        $rose(ext_strobe_n) |-> (strobe_len_q == {1'b0, waits_q} + 5'h01);
    endproperty
    a_len: assert property (p_len)
        else $error("strobe length differs from wait count");

    property p_stable;
        @(posedge clock) disable iff (!arst_n)
        !ext_strobe_n && $past(!ext_strobe_n) |->
            $stable(ext_addr) && $stable(ext_rw);
    endproperty
    a_stable: assert property (p_stable)
        else $error("address moved during wait");

    property p_gap;
        @(posedge clock) disable iff (!arst_n)
        take && gap |=> ext_strobe_n ##1 !ext_strobe_n;
    endproperty
    a_gap: assert property (p_gap)
        else $error("idle cycle not inserted");

    property p_nogap;
        @(posedge clock) disable iff (!arst_n)
        take && !gap |=> !ext_strobe_n;
    endproperty
    a_nogap: assert property (p_nogap)
        else $error("unneeded idle cycle");

    property p_range;
        @(posedge clock) disable iff (!arst_n)
        take |-> (waits >= 4'h1) && (waits <= 4'he) &&
            (double_q || waits <= 4'h7);
    endproperty
    a_range: assert property (p_range)
        else $error("wait count out of range");

    property p_reserved;
        @(posedge clock) disable iff (!arst_n)
        mmr_rd && (mmr_addr == EBW_OFS_BANK_SWITCH) |=>
            (mmr_rdata & ~EBW_WMASK_BANK_SWITCH) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");

    property p_ipi;
        @(posedge clock) disable iff (!arst_n)
        $rose(bank_q[EBW_BIT_INTERPROCESSOR_IRQ_REQUEST]) |=> interprocessor_irq_request
            ##1 !interprocessor_irq_request;
    endproperty
    a_ipi: assert property (p_ipi)
        else $error("interprocessor request not a single pulse");

    property p_off;
        @(posedge clock) disable iff (!arst_n)
        (bank_q[EBW_BIT_BUS_OFF] || !owns) && (state_q == EBW_ST_IDLE) |=>
            ext_strobe_n && !ext_data_oe;
    endproperty
    a_off: assert property (p_off)
        else $error("bus active while switched off");

    c_gap: cover property (@(posedge clock) disable iff (!arst_n)
        take && gap);
    c_double: cover property (@(posedge clock) disable iff (!arst_n)
        take && double_q && waits == 4'he);
    c_off: cover property (@(posedge clock) disable iff (!arst_n)
        acc_end && bank_q[EBW_BIT_BUS_OFF]);
    c_ipi: cover property (@(posedge clock) disable iff (!arst_n)
        interprocessor_irq_request);

endmodule

// ==== testbench/ebw_mem_model.sv ====
/*
 * Behavioural external memory for the bus timing controller.
 * Assumes the controller drives address and strobes on the clock edge.
 */
`timescale 1ns/1ps
module ebw_mem_model (
    // Clock
    input wire logic clock,
    // Bus from the controller
    input wire logic [17:0] ext_addr,
    input wire logic ext_strobe_n,
    input wire logic ext_rw,
    // Data back to the controller
    output logic [15:0] ext_data_i
);
    logic [15:0] last_q = 16'h0000;

    // ============================================================
    // Read data
    // A released bus shows the inverse of the last value driven, so
    // sampling outside the strobe window gives a wrong word.
    always_comb begin
        if (!ext_strobe_n && ext_rw)
            ext_data_i = ext_addr[15:0] ^ 16'h5a5a;
        else
            ext_data_i = ~last_q;
    end

    always_ff @(posedge clock) begin
        if (!ext_strobe_n && ext_rw)
            last_q <= ext_data_i;
    end
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for the external bus timing controller.
 * Assumes one controller that owns the bus and the memory model beside it.
 */
`timescale 1ns/1ps
module tb;
    import ebw_pkg::*;

    typedef struct {
        logic [15:0] bank, rng;
        logic dbl;
        ebw_space_t s0;
        logic [17:0] a0;
        ebw_space_t s1;
        logic [17:0] a1;
        logic [3:0] w;
        logic gap;
    } ebw_row_t;

    localparam ebw_space_t PR = EBW_SP_PROG;
    localparam ebw_space_t DA = EBW_SP_DATA;
    localparam ebw_space_t IO = EBW_SP_IO;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic mmr_wr = 1'b0, mmr_rd = 1'b0, req_valid = 1'b0, req_rd = 1'b1;
    logic [7:0] mmr_addr = 8'h00;
    logic [15:0] mmr_wdata = 16'h0000, req_wdata = 16'h0000;
    ebw_space_t req_space = EBW_SP_DATA;
    logic [17:0] req_addr = 18'h00000, ext_addr;
    logic subsystem_select_pin = 1'b0;
    logic [15:0] mmr_rdata, req_rdata, ext_data_i, ext_data_o, keeper_data;
    logic req_ack, ext_prog_n, ext_data_n, ext_io_n, ext_strobe_n, ext_rw;
    logic ext_data_oe, bus_keeper_enable, mode_bits_locked;
    logic interprocessor_irq_request;
    int fail_count = 0, n_compared = 0, ipi_n = 0, bad = 0, lat, nlow;

    ebw_row_t rows[20] = '{
        '{16'hf800, 16'h7fff, 1'h0, DA, 18'h00010, DA, 18'h00010, 4'h7, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h0, IO, 18'h00010, IO, 18'h00010, 4'h3, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h0, DA, 18'h08000, DA, 18'h08000, 4'h5, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h0, DA, 18'h07fff, DA, 18'h07fff, 4'h2, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h0, PR, 18'h08000, PR, 18'h08000, 4'h6, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h0, PR, 18'h17fff, PR, 18'h17fff, 4'h1, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h1, IO, 18'h00010, IO, 18'h00010, 4'h6, 1'h0},
        '{16'hf800, 16'h3ab0, 1'h1, DA, 18'h08000, DA, 18'h08000, 4'ha, 1'h0},
        '{16'hf800, 16'hbab4, 1'h0, PR, 18'h28000, PR, 18'h28000, 4'h4, 1'h0},
        '{16'hf800, 16'hbab4, 1'h1, PR, 18'h08000, PR, 18'h08000, 4'h8, 1'h0},
        '{16'hf800, 16'h7fff, 1'h1, DA, 18'h00000, DA, 18'h00000, 4'he, 1'h0},
        '{16'hf800, 16'h1249, 1'h0, DA, 18'h01000, DA, 18'h01fff, 4'h1, 1'h0},
        '{16'hf800, 16'h1249, 1'h0, DA, 18'h01000, DA, 18'h02000, 4'h1, 1'h1},
        '{16'h8800, 16'h1249, 1'h0, DA, 18'h01000, DA, 18'h02000, 4'h1, 1'h0},
        '{16'hf800, 16'h1249, 1'h0, PR, 18'h01000, PR, 18'h02000, 4'h1, 1'h1},
        '{16'h0800, 16'h1249, 1'h0, PR, 18'h01000, PR, 18'h11000, 4'h1, 1'h1},
        '{16'h0800, 16'h1249, 1'h0, PR, 18'h01000, DA, 18'h01000, 4'h1, 1'h1},
        '{16'h0800, 16'h1249, 1'h0, DA, 18'h01000, PR, 18'h01000, 4'h1, 1'h1},
        '{16'h0000, 16'h1249, 1'h0, DA, 18'h01000, PR, 18'h01000, 4'h1, 1'h0},
        '{16'hf800, 16'h1249, 1'h0, IO, 18'h01000, IO, 18'h02000, 4'h1, 1'h0}
    };

    always #5 clock = ~clock;

    always @(posedge clock) begin
        if (interprocessor_irq_request === 1'b1)
            ipi_n++;
    end

    ebw_ctrl #(.SUBSYS_ID(1'b0)) DUT (
        .clock, .arst_n, .mmr_wr, .mmr_rd, .mmr_addr, .mmr_wdata,
        .mmr_rdata, .req_valid, .req_space, .req_rd, .req_addr,
        .req_wdata, .req_ack, .req_rdata, .subsystem_select_pin,
        .ext_addr, .ext_prog_n, .ext_data_n, .ext_io_n, .ext_strobe_n,
        .ext_rw, .ext_data_i, .ext_data_o, .ext_data_oe,
        .bus_keeper_enable, .keeper_data, .mode_bits_locked,
        .interprocessor_irq_request
    );

    ebw_mem_model MEM (
        .clock, .ext_addr, .ext_strobe_n, .ext_rw, .ext_data_i
    );

    // ============================================================
    // Shared tasks
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clock);
        mmr_wr <= 1'b1;
        mmr_addr <= a;
        mmr_wdata <= d;
        @(posedge clock);
        mmr_wr <= 1'b0;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [15:0] exp);
        @(posedge clock);
        mmr_rd <= 1'b1;
        mmr_addr <= a;
        @(posedge clock);
        mmr_rd <= 1'b0;
        #1;
        check("mmr_rdata", 18'(mmr_rdata), 18'(exp));
    endtask

    task automatic req_go(ebw_space_t s, logic r, logic [17:0] a);
        @(posedge clock);
        req_valid <= 1'b1;
        req_space <= s;
        req_rd <= r;
        req_addr <= a;
        req_wdata <= a[15:0] ^ 16'h0ff0;
    endtask

    // Counts edges from the take edge to the acknowledge, and watches the
    // pins through every strobe cycle.
    task automatic req_wait(output int lt, output int nl);
        lt = 0;
        nl = 0;
        while (lt < 100) begin
            @(posedge clock);
            #1;
            if (ext_strobe_n === 1'b0) begin
                nl++;
                if (ext_addr !== req_addr || ext_rw !== req_rd)
                    bad++;
                if ({ext_prog_n, ext_data_n, ext_io_n} !==
                    ~(3'b100 >> req_space))
                    bad++;
                if (ext_data_oe !== !req_rd)
                    bad++;
                if (!req_rd && ext_data_o !== req_wdata)
                    bad++;
            end
            if (req_ack === 1'b1)
                break;
            lt++;
        end
        if (lt >= 100) begin
            fail_count++;
            finish_test();
        end
        @(posedge clock);
        req_valid <= 1'b0;
    endtask

    task automatic access(ebw_space_t s, logic r, logic [17:0] a);
        req_go(s, r, a);
        req_wait(lat, nlow);
    endtask

    task automatic held(int n);
        repeat (n) begin
            @(posedge clock);
            #1;
            if (req_ack !== 1'b0 || ext_strobe_n !== 1'b1)
                bad++;
            if (ext_addr !== 18'h00000)
                bad++;
        end
    endtask

    task automatic reset_checks();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        rd_chk(EBW_OFS_WAIT_RANGES, 16'h7fff);
        rd_chk(EBW_OFS_BANK_SWITCH, 16'hf800);
        rd_chk(EBW_OFS_WAIT_MULT, 16'h0000);
        rd_chk(8'h2a, 16'h0000);
        access(DA, 1'b1, 18'h00010);
        check("ack_latency", 18'(lat), 18'h00008);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        reset_checks();
        foreach (rows[i]) begin
            wr(EBW_OFS_BANK_SWITCH, rows[i].bank);
            wr(EBW_OFS_WAIT_RANGES, rows[i].rng);
            wr(EBW_OFS_WAIT_MULT, {15'h0000, rows[i].dbl});
            access(rows[i].s0, 1'b1, rows[i].a0);
            access(rows[i].s1, 1'b1, rows[i].a1);
            check("strobe_cycles", 18'(nlow), 18'(rows[i].w + 1));
            check("ack_latency", 18'(lat),
                  18'(rows[i].w + 1 + rows[i].gap));
            check("req_rdata", 18'(req_rdata),
                  18'(rows[i].a1[15:0] ^ 16'h5a5a));
        end
        check("keeper_data", 18'(keeper_data), 18'h07a5a);
        access(DA, 1'b0, 18'h00040);
        check("keeper_data", 18'(keeper_data), 18'h00fb0);

        // Reserved bits and interprocessor request.
        wr(EBW_OFS_WAIT_MULT, 16'hffff);
        rd_chk(EBW_OFS_WAIT_MULT, 16'h0001);
        wr(EBW_OFS_BANK_SWITCH, 16'hfffe);
        rd_chk(EBW_OFS_BANK_SWITCH, 16'hf904);
        check("ipi_pulses", 18'(ipi_n), 18'h00001);
        check("keeper_en", 18'(bus_keeper_enable), 18'h00001);
        wr(EBW_OFS_BANK_SWITCH, 16'hf900);
        repeat (3) @(posedge clock);
        check("ipi_pulses", 18'(ipi_n), 18'h00001);
        wr(EBW_OFS_BANK_SWITCH, 16'hf800);
        wr(EBW_OFS_BANK_SWITCH, 16'hf900);
        repeat (3) @(posedge clock);
        check("ipi_pulses", 18'(ipi_n), 18'h00002);

        // Bus off in mid-cycle, then a held request.
        wr(EBW_OFS_WAIT_RANGES, 16'h7fff);
        req_go(IO, 1'b1, 18'h00100);
        wr(EBW_OFS_BANK_SWITCH, 16'hf801);
        req_wait(lat, nlow);
        check("ack_latency", 18'(lat), 18'h0000d);
        check("locked", 18'(mode_bits_locked), 18'h00001);
        req_go(IO, 1'b1, 18'h00100);
        held(20);
        wr(EBW_OFS_BANK_SWITCH, 16'hf800);
        req_wait(lat, nlow);
        check("locked", 18'(mode_bits_locked), 18'h00000);

        // Bus owned by the other subsystem.
        @(posedge clock);
        subsystem_select_pin <= 1'b1;
        repeat (5) @(posedge clock);
        req_go(IO, 1'b1, 18'h00100);
        held(20);
        @(posedge clock);
        subsystem_select_pin <= 1'b0;
        req_wait(lat, nlow);

        reset_checks();
        check("bus_faults", 18'(bad), 18'h00000);
        finish_test();
    end
endmodule
